// File: rtl/ccu_pkg.sv
package ccu_pkg;

   // ************************************************************
   // Register map (byte offsets on the bus)
   // ************************************************************
   localparam int          CCU_AW           = 8;
   localparam logic [7:0]  CCU_OFS_WAKE     = 8'h00;
   localparam logic [7:0]  CCU_OFS_PULLDN   = 8'h0c;
   localparam logic [7:0]  CCU_OFS_XIP      = 8'h14;
   localparam logic [7:0]  CCU_OFS_KEY      = 8'h1c;
   localparam logic [7:0]  CCU_OFS_GPIO     = 8'h20;
   localparam logic [7:0]  CCU_OFS_PRIO     = 8'h24;
   localparam logic [7:0]  CCU_OFS_PORT2    = 8'h28;
   localparam logic [7:0]  CCU_OFS_LAST     = 8'h28;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int CCU_NSRC          = 31;
   localparam int CCU_WAKE_FILT_BIT = 31;
   localparam int CCU_PD_LSB        = 20;
   localparam int CCU_PD_W          = 8;
   localparam int CCU_NPORT         = 3;
   localparam int CCU_XIP_MODE_LSB  = 0;
   localparam int CCU_XIP_ENC_LSB   = 8;
   localparam int CCU_GPIO_ON_LSB   = 0;
   localparam int CCU_GPIO_PU_LSB   = 4;
   localparam int CCU_GPIO_DRV_LSB  = 8;
   localparam int CCU_GPIO_OUT_LSB  = 12;
   localparam int CCU_GPIO_IN_LSB   = 16;
   localparam int CCU_PRIO_SYS_BIT  = 0;
   localparam int CCU_PRIO_DISP_BIT = 1;
   localparam int CCU_UNLOCK_LSB    = 30;
   localparam int CCU_P2_W          = 8;

   // ************************************************************
   // Unlock codes, reset values, filter length, responses
   // ************************************************************
   localparam logic [1:0]  CCU_UNLOCK_IDLE  = 2'h0;
   localparam logic [1:0]  CCU_UNLOCK_STEP1 = 2'h1;
   localparam logic [1:0]  CCU_UNLOCK_STEP2 = 2'h2;
   localparam logic [1:0]  CCU_UNLOCK_OPEN  = 2'h3;
   localparam logic [31:0] CCU_RST_WORD     = 32'h0000_0000;
   localparam logic [2:0]  CCU_FILT_LEN     = 3'h4;
   localparam logic [1:0]  CCU_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  CCU_RESP_SLVERR  = 2'h2;
   localparam logic [1:0]  CCU_RESP_DECERR  = 2'h3;

endpackage

// File: rtl/ccu_regs.sv
// Contract
// - Only supervisor accesses; user gets error
// - Filter bit routes wake sources through deglitcher
// - Thirty-one wake source enable bits
// - Bits 0-15 map to IRQ groups a,b
// - Bits 16-20: watchdog, reset, debug, irq, I2C
// - Bits 21-30: group c, comparators, USB, detector
// - Pulldown bits 27:20 drive pulse pin pulldowns
// - Encrypt bit enables XIP data encryption
// - XIP bit places port in XIP
// - Key register writable, always reads zero
// - GPIO bit hands select pin to GPIO
// - Pullup in input mode; drive enable
// - Output level bit drives select pin
// - Input bit reads back pin level
// - Unlock 01,10,11 before priority bits change
// - Writing 00 relocks; others keep 11
// - Read-only priority bits ignore writes, no error
// - Priority bits: MCU first on two RAMs
`timescale 1ns/1ps
module ccu_regs
   import ccu_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   // AXI4-Lite write address and data
   input  wire logic [CCU_AW-1:0]     s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read
   input  wire logic [CCU_AW-1:0]     s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Wakeup sources and request to the power controller
   input  wire logic [CCU_NSRC-1:0]   wake_src_raw,
   output      logic                  wake_req,
   // Pulse pin pulldowns
   output      logic [CCU_PD_W-1:0]   pulldown_bits,
   // Flash controller configuration
   output      logic [CCU_NPORT-1:0]  xip_mode_on,
   output      logic [CCU_NPORT-1:0]  xip_encrypt_on,
   output      logic [31:0]           flash_key,
   // Flash chip-select pins
   input  wire logic [CCU_NPORT-1:0]  ctrl_select_n,
   input  wire logic [CCU_NPORT-1:0]  select_pin_i,
   output      logic [CCU_NPORT-1:0]  select_pin_o,
   output      logic [CCU_NPORT-1:0]  select_pin_oe,
   output      logic [CCU_NPORT-1:0]  select_pullup_on,
   // RAM arbitration and port 2 pin functions
   output      logic                  sysram_mcu_first,
   output      logic                  dispram_mcu_first,
   output      logic [CCU_P2_W-1:0]   port2_function_config
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [31:0]                  wake;
      logic [CCU_PD_W-1:0]          pd;
      logic [CCU_NPORT-1:0]         xip_mode;
      logic [CCU_NPORT-1:0]         xip_enc;
      logic [31:0]                  key;
      logic [CCU_NPORT-1:0]         gp_on;
      logic [CCU_NPORT-1:0]         gp_pu;
      logic [CCU_NPORT-1:0]         gp_drv;
      logic [CCU_NPORT-1:0]         gp_out;
      logic [CCU_NPORT-1:0]         sel_meta;
      logic [CCU_NPORT-1:0]         sel_sync;
      logic                         prio_sys;
      logic                         prio_disp;
      logic [1:0]                   unlock;
      logic [CCU_P2_W-1:0]          p2;
      logic [CCU_NSRC-1:0]          src_meta;
      logic [CCU_NSRC-1:0]          src_sync;
      logic [CCU_NSRC-1:0]          src_filt;
      logic [CCU_NSRC-1:0][2:0]     filt_cnt;
      logic                         wake_req;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
   } ccu_state_t;

   ccu_state_t st_q;
   ccu_state_t st_d;

   // Byte-lane merge for plain read/write registers
   function automatic logic [31:0] ccu_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   logic                  wr_go;
   logic                  rd_go;
   logic [CCU_AW-1:0]     wa;
   logic [CCU_AW-1:0]     ra;
   logic [31:0]           cur;
   logic [31:0]           nw;
   logic [31:0]           rv;
   logic [1:0]            wcode;
   logic [CCU_NSRC-1:0]   src_sel;

   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st_q.bvalid;
   assign rd_go = s_axi_arvalid & ~st_q.rvalid;
   assign wa    = {s_axi_awaddr[CCU_AW-1:2], 2'h0};
   assign ra    = {s_axi_araddr[CCU_AW-1:2], 2'h0};
   assign wcode = s_axi_wdata[CCU_UNLOCK_LSB +: 2];

   always_comb begin
      st_d    = st_q;
      cur     = CCU_RST_WORD;
      nw      = CCU_RST_WORD;
      rv      = CCU_RST_WORD;
      src_sel = '0;

      // Two-flop synchronisers for pins
      st_d.src_meta = wake_src_raw;
      st_d.src_sync = st_q.src_meta;
      st_d.sel_meta = select_pin_i;
      st_d.sel_sync = st_q.sel_meta;

      // Deglitch: a level must hold for the filter length to pass
      for (int i = 0; i < CCU_NSRC; i++) begin
         if (st_q.src_sync[i] == st_q.src_filt[i]) begin
            st_d.filt_cnt[i] = 3'h0;
         end else if (st_q.filt_cnt[i] == CCU_FILT_LEN - 3'h1) begin
            st_d.filt_cnt[i] = 3'h0;
            st_d.src_filt[i] = st_q.src_sync[i];
         end else begin
            st_d.filt_cnt[i] = st_q.filt_cnt[i] + 3'h1;
         end
      end

      // Source index equals enable bit index: groups a,b, then
      // watchdog .. I2C, then group c, comparators, USB, detector
      if (st_q.wake[CCU_WAKE_FILT_BIT]) begin
         src_sel = st_q.src_filt;
      end else begin
         src_sel = st_q.src_sync;
      end
      st_d.wake_req = |(src_sel & st_q.wake[CCU_NSRC-1:0]);

      // ---------------- Write channel ----------------
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_d.bvalid = 1'b1;
         if (!s_axi_awprot[0]) begin
            st_d.bresp = CCU_RESP_SLVERR;
         end else if (wa > CCU_OFS_LAST) begin
            st_d.bresp = CCU_RESP_DECERR;
         end else begin
            st_d.bresp = CCU_RESP_OKAY;
            case (wa)
               CCU_OFS_WAKE: begin
                  st_d.wake = ccu_merge(st_q.wake, s_axi_wdata,
                                        s_axi_wstrb);
               end
               CCU_OFS_PULLDN: begin
                  cur = '0;
                  cur[CCU_PD_LSB +: CCU_PD_W] = st_q.pd;
                  nw  = ccu_merge(cur, s_axi_wdata, s_axi_wstrb);
                  st_d.pd = nw[CCU_PD_LSB +: CCU_PD_W];
               end
               CCU_OFS_XIP: begin
                  cur = '0;
                  cur[CCU_XIP_MODE_LSB +: CCU_NPORT] = st_q.xip_mode;
                  cur[CCU_XIP_ENC_LSB +: CCU_NPORT]  = st_q.xip_enc;
                  nw  = ccu_merge(cur, s_axi_wdata, s_axi_wstrb);
                  st_d.xip_mode = nw[CCU_XIP_MODE_LSB +: CCU_NPORT];
                  st_d.xip_enc  = nw[CCU_XIP_ENC_LSB +: CCU_NPORT];
               end
               CCU_OFS_KEY: begin
                  st_d.key = ccu_merge(st_q.key, s_axi_wdata,
                                       s_axi_wstrb);
               end
               CCU_OFS_GPIO: begin
                  cur = '0;
                  cur[CCU_GPIO_ON_LSB  +: CCU_NPORT] = st_q.gp_on;
                  cur[CCU_GPIO_PU_LSB  +: CCU_NPORT] = st_q.gp_pu;
                  cur[CCU_GPIO_DRV_LSB +: CCU_NPORT] = st_q.gp_drv;
                  cur[CCU_GPIO_OUT_LSB +: CCU_NPORT] = st_q.gp_out;
                  nw  = ccu_merge(cur, s_axi_wdata, s_axi_wstrb);
                  st_d.gp_on  = nw[CCU_GPIO_ON_LSB  +: CCU_NPORT];
                  st_d.gp_pu  = nw[CCU_GPIO_PU_LSB  +: CCU_NPORT];
                  st_d.gp_drv = nw[CCU_GPIO_DRV_LSB +: CCU_NPORT];
                  st_d.gp_out = nw[CCU_GPIO_OUT_LSB +: CCU_NPORT];
               end
               CCU_OFS_PRIO: begin
                  // Priority bits judge the lock as it stood before
                  // this write, so one write cannot unlock and change
                  if (s_axi_wstrb[0] &&
                      st_q.unlock == CCU_UNLOCK_OPEN) begin
                     st_d.prio_sys  = s_axi_wdata[CCU_PRIO_SYS_BIT];
                     st_d.prio_disp = s_axi_wdata[CCU_PRIO_DISP_BIT];
                  end
                  if (s_axi_wstrb[3]) begin
                     if (st_q.unlock == CCU_UNLOCK_OPEN) begin
                        if (wcode == CCU_UNLOCK_IDLE) begin
                           st_d.unlock = CCU_UNLOCK_IDLE;
                        end
                     end else if (wcode == CCU_UNLOCK_STEP1) begin
                        st_d.unlock = CCU_UNLOCK_STEP1;
                     end else if (wcode == CCU_UNLOCK_STEP2 &&
                                  st_q.unlock == CCU_UNLOCK_STEP1) begin
                        st_d.unlock = CCU_UNLOCK_STEP2;
                     end else if (wcode == CCU_UNLOCK_OPEN &&
                                  st_q.unlock == CCU_UNLOCK_STEP2) begin
                        st_d.unlock = CCU_UNLOCK_OPEN;
                     end else begin
                        st_d.unlock = CCU_UNLOCK_IDLE;
                     end
                  end
               end
               CCU_OFS_PORT2: begin
                  cur = '0;
                  cur[CCU_P2_W-1:0] = st_q.p2;
                  nw  = ccu_merge(cur, s_axi_wdata, s_axi_wstrb);
                  st_d.p2 = nw[CCU_P2_W-1:0];
               end
               default: begin
                  // Reserved words swallow the write
                  st_d.bresp = CCU_RESP_OKAY;
               end
            endcase
         end
      end

      // ---------------- Read channel ----------------
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (rd_go) begin
         st_d.rvalid = 1'b1;
         case (ra)
            CCU_OFS_WAKE: begin
               rv = st_q.wake;
            end
            CCU_OFS_PULLDN: begin
               rv[CCU_PD_LSB +: CCU_PD_W] = st_q.pd;
            end
            CCU_OFS_XIP: begin
               rv[CCU_XIP_MODE_LSB +: CCU_NPORT] = st_q.xip_mode;
               rv[CCU_XIP_ENC_LSB +: CCU_NPORT]  = st_q.xip_enc;
            end
            CCU_OFS_GPIO: begin
               rv[CCU_GPIO_ON_LSB  +: CCU_NPORT] = st_q.gp_on;
               rv[CCU_GPIO_PU_LSB  +: CCU_NPORT] = st_q.gp_pu;
               rv[CCU_GPIO_DRV_LSB +: CCU_NPORT] = st_q.gp_drv;
               rv[CCU_GPIO_OUT_LSB +: CCU_NPORT] = st_q.gp_out;
               rv[CCU_GPIO_IN_LSB  +: CCU_NPORT] = st_q.sel_sync;
            end
            CCU_OFS_PRIO: begin
               rv[CCU_PRIO_SYS_BIT]       = st_q.prio_sys;
               rv[CCU_PRIO_DISP_BIT]      = st_q.prio_disp;
               rv[CCU_UNLOCK_LSB +: 2]    = st_q.unlock;
            end
            CCU_OFS_PORT2: begin
               rv[CCU_P2_W-1:0] = st_q.p2;
            end
            default: begin
               // Key and reserved words read as zero
               rv = CCU_RST_WORD;
            end
         endcase
         if (!s_axi_arprot[0]) begin
            st_d.rresp = CCU_RESP_SLVERR;
            st_d.rdata = CCU_RST_WORD;
         end else if (ra > CCU_OFS_LAST) begin
            st_d.rresp = CCU_RESP_DECERR;
            st_d.rdata = CCU_RST_WORD;
         end else begin
            st_d.rresp = CCU_RESP_OKAY;
            st_d.rdata = rv;
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = ~st_q.rvalid;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rresp   = st_q.rresp;
   assign s_axi_rdata   = st_q.rdata;

   assign wake_req              = st_q.wake_req;
   assign pulldown_bits         = st_q.pd;
   assign xip_mode_on           = st_q.xip_mode;
   assign xip_encrypt_on        = st_q.xip_enc;
   assign flash_key             = st_q.key;
   assign sysram_mcu_first      = st_q.prio_sys;
   assign dispram_mcu_first     = st_q.prio_disp;
   assign port2_function_config = st_q.p2;

   // Pin mux: in flash mode the controller always drives its select
   assign select_pin_o  = (st_q.gp_on & st_q.gp_out) |
                          (~st_q.gp_on & ctrl_select_n);
   assign select_pin_oe = (st_q.gp_on & st_q.gp_drv) |
                          ~st_q.gp_on;
   // Pullup only serves an undriven input pin
   assign select_pullup_on = st_q.gp_on & st_q.gp_pu &
                             ~st_q.gp_drv;

endmodule // ccu_regs

// File: testbench/ccu_regs_assertions.sv
`timescale 1ns/1ps
module ccu_regs_assertions
   import ccu_pkg::*;
(
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   // Bus
   input wire logic [CCU_AW-1:0]    s_axi_awaddr,
   input wire logic [2:0]           s_axi_awprot,
   input wire logic                 s_axi_awvalid,
   input wire logic [31:0]          s_axi_wdata,
   input wire logic [3:0]           s_axi_wstrb,
   input wire logic                 s_axi_wvalid,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [CCU_AW-1:0]    s_axi_araddr,
   input wire logic [2:0]           s_axi_arprot,
   input wire logic                 s_axi_arvalid,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic [1:0]           s_axi_rresp,
   input wire logic                 s_axi_rvalid,
   // Wake sources and block outputs
   input wire logic [CCU_NSRC-1:0]  wake_src_raw,
   input wire logic                 wake_req,
   input wire logic [CCU_PD_W-1:0]  pulldown_bits,
   input wire logic [CCU_NPORT-1:0] xip_mode_on,
   input wire logic [CCU_NPORT-1:0] xip_encrypt_on,
   input wire logic [CCU_NPORT-1:0] select_pin_oe,
   input wire logic [CCU_NPORT-1:0] select_pullup_on,
   input wire logic                 sysram_mcu_first
);
   logic        wr_go;
   logic        rd_go;
   logic        full_wr;
   logic [31:0] wd_q;

   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                  && s_axi_awprot[0];
   assign rd_go = s_axi_arvalid && !s_axi_rvalid && s_axi_arprot[0];
   assign full_wr = wr_go && s_axi_wstrb == 4'hf;

   // Last cycle's write data, to compare against what a write stored
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) wd_q <= 32'h0;
      else wd_q <= s_axi_wdata;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   user_wr_err_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      && !s_axi_awprot[0] |=> s_axi_bvalid && s_axi_bresp == CCU_RESP_SLVERR)
      else $error("user write not refused");
   user_rd_err_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arprot[0]
      |=> s_axi_rresp == CCU_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("user read not refused");
   key_rd_zero_a: assert property (rd_go && s_axi_araddr == CCU_OFS_KEY
      |=> s_axi_rresp == CCU_RESP_OKAY && s_axi_rdata == 32'h0)
      else $error("key read not zero");
   rsvd_rd_zero_a: assert property (rd_go
      && s_axi_araddr inside {8'h04, 8'h08, 8'h10, 8'h18}
      |=> s_axi_rresp == CCU_RESP_OKAY && s_axi_rdata == 32'h0)
      else $error("reserved read not zero");
   pd_write_a: assert property (full_wr && s_axi_awaddr == CCU_OFS_PULLDN
      |=> pulldown_bits == wd_q[27:20])
      else $error("pulldown output not updated");
   xip_write_a: assert property (full_wr && s_axi_awaddr == CCU_OFS_XIP
      |=> xip_mode_on == wd_q[2:0] && xip_encrypt_on == wd_q[10:8])
      else $error("flash mode outputs not updated");
   pullup_drive_a: assert property ((select_pullup_on & select_pin_oe) == '0)
      else $error("pullup on while pin driven");
   wake_quiet_a: assert property ((wake_src_raw == '0) [*8] |-> ##2 !wake_req)
      else $error("wake request without source");
   prio_cause_a: assert property ($changed(sysram_mcu_first)
      |-> $past(wr_go) && $past(s_axi_awaddr) == CCU_OFS_PRIO)
      else $error("priority changed without write");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   cover property (wr_go && s_axi_awaddr == CCU_OFS_PRIO);
   cover property ($rose(wake_req));
   cover property (s_axi_bvalid && s_axi_bresp == CCU_RESP_SLVERR);
endmodule // ccu_regs_assertions

bind ccu_regs ccu_regs_assertions ccu_regs_assertions_i (
   .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .wake_src_raw(wake_src_raw), .wake_req(wake_req),
   .pulldown_bits(pulldown_bits), .xip_mode_on(xip_mode_on),
   .xip_encrypt_on(xip_encrypt_on), .select_pin_oe(select_pin_oe),
   .select_pullup_on(select_pullup_on),
   .sysram_mcu_first(sysram_mcu_first));

// File: testbench/ccu_regs_test.sv
`timescale 1ns/1ps
module ccu_regs_test
   import ccu_pkg::*;
;
   logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, wake_req;
   logic sysram_mcu_first, dispram_mcu_first;
   logic [CCU_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, flash_key;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [CCU_NSRC-1:0] wake_src_raw;
   logic [CCU_PD_W-1:0] pulldown_bits;
   logic [CCU_P2_W-1:0] port2_function_config;
   logic [CCU_NPORT-1:0] xip_mode_on, xip_encrypt_on, ctrl_select_n;
   logic [CCU_NPORT-1:0] select_pin_i, select_pin_o, select_pin_oe;
   logic [CCU_NPORT-1:0] select_pullup_on;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   int srcs[7] = '{0, 15, 16, 18, 20, 25, 30};

   ccu_regs ccu_regs_i (.*);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Cuts a hang short; the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ************************************************************
   // Bus tasks: bready and rready are held high for the whole run
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = CCU_RESP_OKAY,
                     input logic [3:0] s = 4'hf, input logic p = 1'b1);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awprot <= {2'h0, p};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while ((s_axi_awready && s_axi_wready) !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do begin
         @(posedge ref_clk);
      end while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = CCU_RESP_OKAY,
                     input logic p = 1'b1);
      s_axi_araddr <= a;
      s_axi_arprot <= {2'h0, p};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge ref_clk);
      end while (s_axi_rvalid !== 1'b1);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      chk($sformatf("rdata at %h", a), e, s_axi_rdata);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      nrst = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_wdata, s_axi_wstrb, wake_src_raw} = '0;
      select_pin_i = 3'h5;
      ctrl_select_n = 3'h3;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      for (int a = 0; a <= 8'h28; a += 4) begin
         rd(8'(a), (a == 8'h20) ? 32'h0005_0000 : 32'h0);
      end
      rd(8'h2c, 32'h0, CCU_RESP_DECERR);
      wr(8'h2c, 32'h1, CCU_RESP_DECERR);
      wr(CCU_OFS_PULLDN, '1, CCU_RESP_SLVERR, 4'hf, 1'b0);
      chk("pulldown_bits", 32'h0, 32'(pulldown_bits));
      rd(CCU_OFS_PORT2, 32'h0, CCU_RESP_SLVERR, 1'b0);
      wr(8'h04, '1, CCU_RESP_SLVERR, 4'hf, 1'b0);
      wr(8'h08, '1);
      rd(8'h08, 32'h0);
      wr(CCU_OFS_PULLDN, '1);
      rd(CCU_OFS_PULLDN, 32'h0ff0_0000);
      wr(CCU_OFS_PULLDN, 32'h0110_0000);
      chk("pulldown_bits", 32'h11, 32'(pulldown_bits));
      wr(CCU_OFS_XIP, 32'h0000_0501);
      chk("xip_mode_on", 32'h1, 32'(xip_mode_on));
      chk("xip_encrypt_on", 32'h5, 32'(xip_encrypt_on));
      rd(CCU_OFS_XIP, 32'h0000_0501);
      wr(CCU_OFS_KEY, 32'ha5a5_5a5a);
      chk("flash_key", 32'ha5a5_5a5a, flash_key);
      rd(CCU_OFS_KEY, 32'h0);
      wr(CCU_OFS_GPIO, 32'h0000_2617);
      chk("select_pin_oe", 32'h6, 32'(select_pin_oe));
      chk("select_pin_o", 32'h2, 32'(select_pin_o & 3'h6));
      chk("select_pullup_on", 32'h1, 32'(select_pullup_on));
      select_pin_i <= 3'h2;
      repeat (3) @(posedge ref_clk);
      rd(CCU_OFS_GPIO, 32'h0002_2617);
      wr(CCU_OFS_GPIO, 32'h0);
      chk("select_pin_oe", 32'h7, 32'(select_pin_oe));
      chk("select_pin_o", 32'h3, 32'(select_pin_o));
      wr(CCU_OFS_PORT2, '1, CCU_RESP_OKAY, 4'h0);
      rd(CCU_OFS_PORT2, 32'h0);
      wr(CCU_OFS_PORT2, 32'h0000_00c3);
      chk("port2", 32'hc3, 32'(port2_function_config));
      wr(CCU_OFS_PRIO, 32'h3);
      chk("sysram_mcu_first", 32'h0, 32'(sysram_mcu_first));
      wr(CCU_OFS_PRIO, 32'h4000_0000);
      wr(CCU_OFS_PRIO, 32'hc000_0000);
      wr(CCU_OFS_PRIO, 32'h8000_0003);
      rd(CCU_OFS_PRIO, 32'h0);
      wr(CCU_OFS_PRIO, 32'h4000_0000);
      wr(CCU_OFS_PRIO, 32'h8000_0000);
      wr(CCU_OFS_PRIO, 32'hc000_0000);
      rd(CCU_OFS_PRIO, 32'hc000_0000);
      wr(CCU_OFS_PRIO, 32'h7fff_ffff);
      rd(CCU_OFS_PRIO, 32'hc000_0003);
      chk("both priorities", 32'h3,
          32'({dispram_mcu_first, sysram_mcu_first}));
      wr(CCU_OFS_PRIO, 32'h0000_0001);
      rd(CCU_OFS_PRIO, 32'h0000_0001);
      wr(CCU_OFS_PRIO, 32'h0000_0002);
      rd(CCU_OFS_PRIO, 32'h0000_0001);
      foreach (srcs[i]) begin
         wr(CCU_OFS_WAKE, 32'h1 << srcs[i]);
         wake_src_raw <= 31'h1 << srcs[i];
         repeat (5) @(posedge ref_clk);
         chk("wake_req on", 32'h1, 32'(wake_req));
         wake_src_raw <= ~(31'h1 << srcs[i]);
         repeat (5) @(posedge ref_clk);
         chk("wake_req off", 32'h0, 32'(wake_req));
      end
      wake_src_raw <= '0;
      wr(CCU_OFS_WAKE, 32'h8000_0001);
      repeat (10) @(posedge ref_clk);
      wake_src_raw <= 31'h1;
      repeat (2) @(posedge ref_clk);
      wake_src_raw <= '0;
      repeat (10) @(posedge ref_clk);
      chk("wake_req glitch", 32'h0, 32'(wake_req));
      wake_src_raw <= 31'h1;
      repeat (10) @(posedge ref_clk);
      chk("wake_req filtered", 32'h1, 32'(wake_req));
      wr(CCU_OFS_PRIO, 32'h4000_0000);
      wr(CCU_OFS_PRIO, 32'h8000_0000);
      wr(CCU_OFS_PRIO, 32'hc000_0000);
      rd(CCU_OFS_PRIO, 32'hc000_0001);
      wake_src_raw <= '0;
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rd(CCU_OFS_XIP, 32'h0);
      rd(CCU_OFS_PRIO, 32'h0);
      results();
   end
endmodule // ccu_regs_test
